// ==== rtl/svd_map.svh ====
/*
 * Register offsets, field positions, reset values and timing counts for the
 * supply voltage detector control block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef SVD_MAP_SVH
`define SVD_MAP_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define SVD_CTRL_ADDR 4'h0
`define SVD_STAT_ADDR 4'h4
`define SVD_MASK_ADDR 4'h8
`define SVD_GIE_ADDR 4'hC

// ****************************************
// Control register fields
// ****************************************
`define SVD_DIR_BIT 7
`define SVD_STABLE_BIT 5
`define SVD_EN_BIT 4
`define SVD_LVL_ALL1 4'hF
`define SVD_CTRL_RESET 8'h05
`define SVD_CTRL_WMASK 8'h9F

// ****************************************
// Settling time
// ****************************************
`define SVD_CLK_MHZ 125
`define SVD_SETTLE_NS 1000
`define SVD_SETTLE_CYC ((`SVD_SETTLE_NS * `SVD_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/svd_pkg.sv ====
/*
 * Types for the supply voltage detector control block.
 * Assumes the map header supplies numeric constants.
 */
package svd_pkg;

  // Control register layout
  typedef struct packed {
    logic dir;
    logic rsvd;
    logic stable;
    logic en;
    logic [3:0] level;
  } svd_ctrl_t;

  // Analog side inputs
  typedef struct packed {
    logic trip_below;
    logic trip_above;
    logic ref_ready;
  } svd_ana_t;

  typedef enum logic [1:0] {
    SVD_OFF,
    SVD_SETTLE,
    SVD_ON
  } svd_state_t;

endpackage : svd_pkg

// ==== rtl/svd_ctrl.sv ====
/*
 * Supply voltage detector control: control register, settling sequence,
 * qualified trip event, sticky flag, mask and interrupt over Wishbone.
 * Assumes analog comparator outputs asynchronous to clk_i, a classic
 * Wishbone master, and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "svd_map.svh"

module svd_ctrl
  import svd_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `SVD_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic trip_below_i,
  input wire logic trip_above_i,
  input wire logic ref_ready_i,
  output logic detector_power_enable_o,
  output logic [3:0] trip_level_select_o,
  output logic external_trip_input_sel_o,
  output logic wake_o,
  output logic irq_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  svd_ana_t ana_meta_r;
  svd_ana_t ana_sync_r;

  // Two flops, first read only by second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_meta_r <= '0;
      ana_sync_r <= '0;
    end else begin
      ana_meta_r <= '{trip_below_i, trip_above_i, ref_ready_i};
      ana_sync_r <= ana_meta_r;
    end
  end

  // ****************************************
  // Registers and bus
  // ****************************************
  svd_ctrl_t ctrl_r, ctrl_nxt;
  logic flag_r, flag_nxt;
  logic mask_r, mask_nxt;
  logic gie_r, gie_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  svd_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic stable;
  logic trip;
  logic bus_req;
  logic wr;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = bus_req && wb_we_i && wb_sel_i[0];
  assign stable = (state_r == SVD_ON);

  // Trip qualified by direction; comparator already sees the chosen tap
  assign trip = ctrl_r.dir ? ana_sync_r.trip_above : ana_sync_r.trip_below;

  // Register next values
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    gie_nxt = gie_r;
    flag_nxt = flag_r;
    ack_nxt = bus_req;
    rdat_nxt = '0;
    if (wr && wb_adr_i == `SVD_CTRL_ADDR) begin
      // Stable and reserved bits not writable
      ctrl_nxt = svd_ctrl_t'(wb_dat_i[7:0] & `SVD_CTRL_WMASK);
    end
    if (wr && wb_adr_i == `SVD_MASK_ADDR) begin
      mask_nxt = wb_dat_i[0];
    end
    if (wr && wb_adr_i == `SVD_GIE_ADDR) begin
      gie_nxt = wb_dat_i[0];
    end
    // Write one to clear
    if (wr && wb_adr_i == `SVD_STAT_ADDR && wb_dat_i[0]) begin
      flag_nxt = 1'b0;
    end
    // Set wins over clear; only when stable; runs in sleep too
    if (ctrl_r.en && stable && trip) begin
      flag_nxt = 1'b1;
    end
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `SVD_CTRL_ADDR: rdat_nxt = {24'h000000, ctrl_r.dir, 1'b0, stable, ctrl_r.en,
                                    ctrl_r.level};
        `SVD_STAT_ADDR: rdat_nxt = {31'h00000000, flag_r};
        `SVD_MASK_ADDR: rdat_nxt = {31'h00000000, mask_r};
        `SVD_GIE_ADDR: rdat_nxt = {31'h00000000, gie_r};
        default: rdat_nxt = '0;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= svd_ctrl_t'(`SVD_CTRL_RESET);
      flag_r <= 1'b0;
      mask_r <= 1'b0;
      gie_r <= 1'b0;
      ack_r <= 1'b0;
      rdat_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      gie_r <= gie_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ****************************************
  // Settling sequence
  // ****************************************

  // Settle count then reference ready before stable
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      SVD_OFF: begin
        cnt_nxt = '0;
        if (ctrl_r.en) begin
          state_nxt = SVD_SETTLE;
        end
      end
      SVD_SETTLE: begin
        if (cnt_r < 16'(SETTLE_CYC)) begin
          cnt_nxt = cnt_r + 16'h0001;
        end else if (ana_sync_r.ref_ready) begin
          state_nxt = SVD_ON;
        end
      end
      SVD_ON: begin
        cnt_nxt = '0;
      end
      default: begin
        state_nxt = SVD_OFF;
      end
    endcase
    if (!ctrl_r.en) begin
      state_nxt = SVD_OFF;
    end
  end

  // Settling state and count storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SVD_OFF;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign detector_power_enable_o = ctrl_r.en;
  assign trip_level_select_o = ctrl_r.level;
  assign external_trip_input_sel_o = (ctrl_r.level == `SVD_LVL_ALL1);
  assign irq_o = flag_r && mask_r && gie_r;
  assign wake_o = flag_r && mask_r && sleep_i;

  // ****************************************
  // Checks: settling, control and inputs
  // ****************************************

  // No stable flag in the first cycles after enable
  a_stable_after_en: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ctrl_r.en) |=> !stable [*2])
    else $error("stable flag high too soon after enable");

  // Stable rises only at the end of the count with reference ready
  a_settle_done: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(stable) |-> $past(cnt_r) == 16'(SETTLE_CYC) && $past(ana_sync_r.ref_ready))
    else $error("stable flag rose before settling ended");

  // Stable stays while the detector stays on
  a_stable_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (stable && ctrl_r.en) |=> stable)
    else $error("stable flag dropped while enabled");

  // Read-only and reserved bits never stored
  a_ro_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_r.stable && !ctrl_r.rsvd)
    else $error("read-only control bit stored");

  // Disabling drops stable the next cycle
  a_off_drops_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_r.en |=> !stable)
    else $error("stable held while disabled");

  // Control fields change only on a bus write
  a_ctrl_write_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr |=> $stable(ctrl_r))
    else $error("control register changed without a write");

  // External input selected exactly at the all-ones code
  a_ext_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    external_trip_input_sel_o == (trip_level_select_o == 4'hF))
    else $error("external input selected at wrong code");

  // Two-cycle latency on reference ready
  a_sync_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ref_ready_i) ##1 ref_ready_i |=> ana_sync_r.ref_ready)
    else $error("synchroniser delay wrong");

  // Two-cycle latency on the low comparator
  a_sync_trip: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(trip_below_i) ##1 trip_below_i |=> ana_sync_r.trip_below)
    else $error("comparator synchroniser delay wrong");

  // Reset leaves the detector off and the flag clear
  a_reset_off: assert property (@(posedge clk_i)
    rst_i |=> !detector_power_enable_o && !flag_r)
    else $error("reset did not turn detector off");

  // ****************************************
  // Checks: event flag and interrupt
  // ****************************************

  // Flag never rises unless stable before
  a_flag_needs_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_r) |-> $past(stable))
    else $error("event flag set while not stable");

  // No event while the detector is off
  a_off_no_event: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_r.en && !flag_r) |=> !flag_r)
    else $error("event flag set while disabled");

  // Qualified trip sets the flag next cycle
  a_trip_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r.en && stable && trip) |=> flag_r)
    else $error("qualified trip did not set flag");

  // Flag sticks until a one is written to it
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_r && !(wr && wb_adr_i == `SVD_STAT_ADDR && wb_dat_i[0])) |=> flag_r)
    else $error("event flag lost without clear");

  // Low detect ignores a rise above the trip point
  a_dir_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_r.dir && ana_sync_r.trip_above && !ana_sync_r.trip_below && !flag_r)
    |=> !flag_r)
    else $error("low detect tripped on rise");

  // High detect ignores a drop below the trip point
  a_dir_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r.dir && ana_sync_r.trip_below && !ana_sync_r.trip_above && !flag_r)
    |=> !flag_r)
    else $error("high detect tripped on drop");

  // Detection goes on during sleep
  a_sleep_detect: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && ctrl_r.en && stable && trip) |=> flag_r)
    else $error("trip in sleep did not set flag");

  // Interrupt only from flag and both enables
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == (flag_r && mask_r && gie_r))
    else $error("interrupt not gated by flag and enables");

  // Enabled trip raises the interrupt next cycle
  a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wr && ctrl_r.en && stable && trip && mask_r && gie_r) |=> irq_o)
    else $error("enabled trip did not raise interrupt");

endmodule : svd_ctrl

// ==== test/svd_ana_model.sv ====
/* Analog side model: reference start-up and supply comparator.
   Assumes the control block drives power, level and external select. */
`timescale 1ns/100ps
module svd_ana_model
  import svd_pkg::*;
#(
  parameter int READY_CYC = 3
) (
  input wire logic clk_i,
  input wire logic power_i,
  input wire logic [3:0] level_i,
  input wire logic ext_sel_i,
  input wire logic [3:0] supply_i,
  input wire logic [3:0] ext_pin_i,
  output svd_ana_t ana_o
);
  // ****************************************
  // Reference start-up and comparator
  // ****************************************
  logic [3:0] cnt_r = 4'h0;
  logic tgl_r = 1'b0;
  logic [3:0] thr;
  // Count start-up while powered; toggle stands for an unpowered output
  always_ff @(posedge clk_i) begin
    tgl_r <= ~tgl_r;
    if (!power_i) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'(READY_CYC)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // Higher level code means higher trip point
  assign thr = ext_sel_i ? ext_pin_i : level_i;
  assign ana_o.ref_ready = power_i && cnt_r == 4'(READY_CYC);
  assign ana_o.trip_below = power_i ? supply_i <= thr : tgl_r;
  assign ana_o.trip_above = power_i ? supply_i >= thr : ~tgl_r;
endmodule : svd_ana_model

// ==== test/svd_ctrl_tb.sv ====
/* Bench for the detector control block over Wishbone.
   Assumes svd_ana_model stands for the analog side. */
`timescale 1ns/100ps
`include "svd_map.svh"
module svd_ctrl_tb
  import svd_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0;
  logic [3:0] adr = 4'h0, supply = 4'h0, ext_pin = 4'h8, lvl;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic wb_ack_o, pwr, ext_sel, wake_o, irq_o;
  svd_ana_t ana;
  int fails = 0, comparisons = 0;
  always #4 clk_i = ~clk_i;
  svd_ana_model #(.READY_CYC(3)) u_ana (.clk_i(clk_i), .power_i(pwr), .level_i(lvl),
    .ext_sel_i(ext_sel), .supply_i(supply), .ext_pin_i(ext_pin), .ana_o(ana));
  svd_ctrl #(.SETTLE_CYC(12)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep),
    .trip_below_i(ana.trip_below), .trip_above_i(ana.trip_above),
    .ref_ready_i(ana.ref_ready), .detector_power_enable_o(pwr),
    .trip_level_select_o(lvl), .external_trip_input_sel_o(ext_sel),
    .wake_o(wake_o), .irq_o(irq_o));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h, expected %h", $time, s, e);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) fails++;
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h0);
    chk(q, {24'h0, e});
  endtask : rd
  task automatic wait_stable();
    for (int i = 0; i < 30; i++) begin
      wb(1'b0, `SVD_CTRL_ADDR, 8'h0);
      if (q[`SVD_STABLE_BIT] === 1'b1) break;
    end
    chk(32'(q[`SVD_STABLE_BIT]), 32'h1);
  endtask : wait_stable
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(`SVD_CTRL_ADDR, 8'h05);
    rd(`SVD_STAT_ADDR, 8'h00);
    chk(32'({pwr, irq_o}), 32'h0);
    wb(1'b1, 4'h6, 8'hFF);
    rd(4'h6, 8'h00);
  endtask : t_reset
  // Trip present before settling, external level selected
  task automatic t_settle();
    wb(1'b1, `SVD_CTRL_ADDR, 8'h1F);
    rd(`SVD_CTRL_ADDR, 8'h1F);
    chk(32'({pwr, ext_sel, lvl}), 32'h3F);
    rd(`SVD_STAT_ADDR, 8'h00);
    wait_stable();
    repeat (3) @(posedge clk_i);
    rd(`SVD_STAT_ADDR, 8'h01);
    wb(1'b1, `SVD_CTRL_ADDR, 8'h5F);
    rd(`SVD_CTRL_ADDR, 8'h3F);
    wb(1'b1, `SVD_CTRL_ADDR, 8'h05);
    @(posedge clk_i);
    chk(32'(pwr), 32'h0);
    rd(`SVD_CTRL_ADDR, 8'h05);
    wb(1'b1, `SVD_STAT_ADDR, 8'h01);
    rd(`SVD_STAT_ADDR, 8'h00);
  endtask : t_settle
  // Setup order, boundary trip, irq, mask and sleep wake
  task automatic t_trip(input logic dir);
    wb(1'b1, `SVD_CTRL_ADDR, 8'h05);
    wb(1'b1, `SVD_CTRL_ADDR, {dir, 7'h05});
    wb(1'b1, `SVD_CTRL_ADDR, {dir, 7'h15});
    chk(32'({pwr, ext_sel, lvl}), 32'h25);
    supply <= dir ? 4'h1 : 4'h9;
    wait_stable();
    wb(1'b1, `SVD_STAT_ADDR, 8'h01);
    wb(1'b1, `SVD_MASK_ADDR, 8'h01);
    wb(1'b1, `SVD_GIE_ADDR, 8'h01);
    rd(`SVD_STAT_ADDR, 8'h00);
    chk(32'(irq_o), 32'h0);
    sleep <= 1'b1;
    supply <= 4'h5;
    repeat (6) @(posedge clk_i);
    rd(`SVD_STAT_ADDR, 8'h01);
    chk(32'({irq_o, wake_o}), 32'h3);
    sleep <= 1'b0;
    @(posedge clk_i);
    chk(32'(wake_o), 32'h0);
    wb(1'b1, `SVD_GIE_ADDR, 8'h00);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, `SVD_GIE_ADDR, 8'h01);
    wb(1'b1, `SVD_MASK_ADDR, 8'h00);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    supply <= dir ? 4'h1 : 4'h9;
    repeat (6) @(posedge clk_i);
    wb(1'b1, `SVD_STAT_ADDR, 8'h01);
    rd(`SVD_STAT_ADDR, 8'h00);
  endtask : t_trip
  // Reset in mid-run returns the control, mask and GIE registers to their reset values
  task automatic t_rerst();
    wb(1'b1, `SVD_CTRL_ADDR, 8'h9A);
    wb(1'b1, `SVD_MASK_ADDR, 8'h01);
    wb(1'b1, `SVD_GIE_ADDR, 8'h01);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SVD_CTRL_ADDR, 8'h05);
    chk(32'(pwr), 32'h0);
    rd(`SVD_MASK_ADDR, 8'h00);
    rd(`SVD_GIE_ADDR, 8'h00);
  endtask : t_rerst
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_settle();
    t_trip(1'b0);
    t_trip(1'b1);
    t_rerst();
    give_verdict();
  end
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
endmodule : svd_ctrl_tb
